// ==== core/lps_supervisor.sv ====
// Line power and hook supervisor: thermal power alarms, loop closure
// detection, line open control, calibration start and register port.
// Assumes monitor readings arrive on mclk from the converter logic.
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "lps_defs.svh"

module lps_supervisor
  import lps_pkg::*;
#(
  parameter int SAMPLE_DIV = `LPS_MCLK_HZ / `LPS_SAMPLE_RATE_HZ,
  parameter int CAL_CYCLES = `LPS_CAL_TIME_US * (`LPS_MCLK_HZ / 1000000)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire lps_bus_req_type bus_req,
  output var logic [15:0] bus_rdata,
  // Monitor converter readings
  input wire lps_monitor_type mon,
  // Line and status outputs
  output var logic [2:0] line_state_select,
  output var logic cal_active,
  output var logic irq_request,
  output var logic closure_detected
);

  // Reset release synchroniser
  logic rst_meta_reg;
  logic rst_n;

  // Release is synchronous so no flop sees a half-released reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Software visible registers
  logic [7:0] event_pending_reg;      // Sticky events
  logic [7:0] event_enable_reg;       // Interrupt enables
  logic [7:0] alarm_disconnect_reg;   // Auto-disconnect control
  logic [7:0] debounce_reg;           // Closure debounce interval
  logic [7:0] probe_pointer_reg;      // Power probe select
  logic [7:0] hook_options_reg;       // Hysteresis and voltage mode
  logic [15:0] hook_upper_reg;        // Closure upper limit
  logic [15:0] hook_lower_reg;        // Closure lower limit
  logic [15:0] hook_coeff_reg;        // Closure filter coefficient
  logic [2:0][15:0] pair_limit_reg;   // Power limit per pair
  logic [2:0][15:0] pair_pole_reg;    // Thermal coefficient per pair

  // Internal state
  logic [15:0] div_cnt_reg;           // 800 Hz divider
  logic tick_reg;                     // One-cycle sample enable
  logic comp_reg;                     // Threshold comparator state
  logic [6:0] debounce_cnt_reg;       // Debounce interval counter
  logic [15:0] cal_cnt_reg;           // Calibration timer
  lps_cal_state_type cal_state_reg;
  lps_cal_state_type cal_state_next;

  // Write strobes decoded per register
  wire logic wr_pending = bus_req.wr && bus_req.addr == `LPS_OFS_EVENT_PENDING;
  wire logic wr_enable = bus_req.wr && bus_req.addr == `LPS_OFS_EVENT_ENABLE;
  wire logic wr_line = bus_req.wr && bus_req.addr == `LPS_OFS_LINE_STATE;
  wire logic wr_disc = bus_req.wr && bus_req.addr == `LPS_OFS_ALARM_DISC;
  wire logic wr_deb = bus_req.wr && bus_req.addr == `LPS_OFS_HOOK_DEBOUNCE;
  wire logic wr_ptr = bus_req.wr && bus_req.addr == `LPS_OFS_PROBE_POINTER;
  wire logic wr_trim = bus_req.wr && bus_req.addr == `LPS_OFS_LINE_TRIM;
  wire logic wr_opt = bus_req.wr && bus_req.addr == `LPS_OFS_HOOK_OPTIONS;
  wire logic wr_upper = bus_req.wr && bus_req.addr == `LPS_OFS_HOOK_UPPER;
  wire logic wr_lower = bus_req.wr && bus_req.addr == `LPS_OFS_HOOK_LOWER;
  wire logic wr_coeff = bus_req.wr && bus_req.addr == `LPS_OFS_HOOK_COEFF;
  wire logic [2:0] wr_limit = {3{bus_req.wr}} & {
      bus_req.addr == `LPS_OFS_PAIR_C_LIMIT,
      bus_req.addr == `LPS_OFS_PAIR_B_LIMIT,
      bus_req.addr == `LPS_OFS_PAIR_A_LIMIT};
  wire logic [2:0] wr_pole = {3{bus_req.wr}} & {
      bus_req.addr == `LPS_OFS_PAIR_C_POLE,
      bus_req.addr == `LPS_OFS_PAIR_B_POLE,
      bus_req.addr == `LPS_OFS_PAIR_A_POLE};

  // Sample tick divider: converter delivers fresh readings at 800 Hz
  wire logic div_wrap = div_cnt_reg == 16'(SAMPLE_DIV - 1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= `LPS_RST_WORD;
      tick_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_wrap ? `LPS_RST_WORD : div_cnt_reg + 16'h0001;
      tick_reg <= div_wrap;
    end
  end

  // Power filter inputs, one per transistor plus one loop channel
  logic [6:0][15:0] filt_in;
  logic [6:0][15:0] filt_coeff;
  logic [6:0][15:0] filt_out;
  logic [6:0] filt_en;
  logic [5:0] alarm_now;

  // Transistor channels: scale, filter and compare per transistor
  generate
    for (genvar i = 0; i < 6; i++) begin : g_power
      // Pair index of transistor i
      localparam int PAIR = i / 2;
      // Middle pair carries a finer power resolution
      assign filt_in[i] = (PAIR == 1) ?
          16'(mon.power[i]) << `LPS_PAIR_B_SHIFT :
          16'(mon.power[i]) << `LPS_PAIR_AC_SHIFT;
      assign filt_coeff[i] = pair_pole_reg[PAIR];
      assign filt_en[i] = tick_reg;
      // Overload when the filtered power rises above the pair limit
      assign alarm_now[i] = tick_reg && filt_out[i] > pair_limit_reg[PAIR];
    end
    for (genvar i = 0; i < 7; i++) begin : g_filter
      lps_lowpass u_lowpass (
        .clk(mclk),
        .rst_n(rst_n),
        .sample_en(filt_en[i]),
        .sample_in(filt_in[i]),
        .coeff(filt_coeff[i]),
        .filt_out(filt_out[i])
      );
    end
  endgenerate

  // Loop closure front end
  wire logic state_on_hook =
      mon.line_state_shadow == 3'h1 || mon.line_state_shadow == 3'h2 ||
      mon.line_state_shadow == 3'h5 || mon.line_state_shadow == 3'h6;
  // Revision C options, inert on earlier silicon
  wire logic hyst_on = `LPS_REV_C_FEATURES & hook_options_reg[`LPS_BIT_HYST_ON];
  wire logic by_voltage = `LPS_REV_C_FEATURES & hook_options_reg[`LPS_BIT_BY_VOLTAGE];
  // Sign is dropped; only the 6-bit magnitude is thresholded
  wire logic [5:0] loop_mag = by_voltage ? mon.loop_voltage_sample[5:0] :
      mon.loop_current_sample[5:0];
  wire logic hook_tick = tick_reg && state_on_hook;

  assign filt_in[6] = {loop_mag, 10'h000};
  assign filt_coeff[6] = {3'h0, hook_coeff_reg[12:0]};
  assign filt_en[6] = hook_tick;

  // Threshold comparison with optional hysteresis
  wire logic [5:0] loop_level = filt_out[6][15:`LPS_LOOP_SHIFT];
  wire logic [5:0] upper = hook_upper_reg[5:0];
  wire logic [5:0] lower = hook_lower_reg[5:0];
  wire logic above_up = loop_level > upper;
  wire logic below_up = loop_level < upper;
  wire logic below_lo = loop_level < lower;
  // Current mode: closed above upper; released below lower with hysteresis, else at or below upper
  wire logic comp_cur = hyst_on ?
      (above_up ? 1'b1 : (below_lo ? 1'b0 : comp_reg)) : above_up;
  // Voltage mode: with hysteresis closed below lower, released above upper; else closed below upper
  wire logic comp_volt = hyst_on ?
      (below_lo ? 1'b1 : (above_up ? 1'b0 : comp_reg)) : below_up;
  wire logic comp_next = by_voltage ? comp_volt : comp_cur;

  // Debounce: count ticks while comparator disagrees with output
  wire logic disagree = comp_reg != closure_detected;
  wire logic deb_done = disagree && debounce_cnt_reg >= debounce_reg[6:0];
  wire logic closure_rise = hook_tick && deb_done && comp_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      comp_reg <= 1'b0;
      debounce_cnt_reg <= 7'h00;
      closure_detected <= 1'b0;
    end else if (hook_tick) begin
      comp_reg <= comp_next;
      // Any agreeing tick restarts the interval
      debounce_cnt_reg <= (disagree && !deb_done) ? debounce_cnt_reg + 7'h01 : 7'h00;
      if (deb_done) begin
        closure_detected <= comp_reg;
      end
    end
  end

  // Sticky events; a set in the clearing cycle survives
  wire logic [7:0] event_set = {alarm_now, closure_rise, 1'b0};
  wire logic [7:0] event_clr = wr_pending ? bus_req.wdata[7:0] : 8'h00;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      event_pending_reg <= `LPS_RST_BYTE;
      irq_request <= 1'b0;
    end else begin
      event_pending_reg <= (event_pending_reg & ~event_clr) | event_set;
      // Only enabled pending events reach the request line
      irq_request <= |(event_pending_reg & event_enable_reg);
    end
  end

  // Line state: open at reset, forced open by overload
  wire logic force_open = |alarm_now && alarm_disconnect_reg[`LPS_BIT_AUTO_DISC];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_state_select <= `LPS_LINE_OPEN;
    end else if (force_open) begin
      line_state_select <= `LPS_LINE_OPEN;
    end else if (wr_line) begin
      line_state_select <= bus_req.wdata[2:0];
    end
  end

  // Calibration sequencer
  wire logic trim_start = wr_trim && bus_req.wdata[`LPS_BIT_TRIM_START];
  wire logic cal_expired = cal_cnt_reg == 16'(CAL_CYCLES - 1);

  always_comb begin
    cal_state_next = cal_state_reg;
    case (cal_state_reg)
      LPS_CAL_IDLE: begin
        if (trim_start) begin
          cal_state_next = LPS_CAL_RUN;
        end
      end
      LPS_CAL_RUN: begin
        if (cal_expired) begin
          cal_state_next = LPS_CAL_DONE;
        end
      end
      default: begin
        cal_state_next = LPS_CAL_IDLE;
      end
    endcase
  end

  // Engine owns battery, tip and ring drive while running
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cal_state_reg <= LPS_CAL_IDLE;
      cal_cnt_reg <= `LPS_RST_WORD;
      cal_active <= 1'b0;
    end else begin
      cal_state_reg <= cal_state_next;
      cal_cnt_reg <= (cal_state_reg == LPS_CAL_RUN) ? cal_cnt_reg + 16'h0001 : `LPS_RST_WORD;
      cal_active <= cal_state_next == LPS_CAL_RUN;
    end
  end

  // Plain read/write registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      event_enable_reg <= `LPS_RST_BYTE;
      alarm_disconnect_reg <= `LPS_RST_BYTE;
      debounce_reg <= `LPS_RST_BYTE;
      probe_pointer_reg <= `LPS_RST_BYTE;
      hook_options_reg <= `LPS_RST_BYTE;
    end else begin
      if (wr_enable) event_enable_reg <= bus_req.wdata[7:0];
      if (wr_disc) alarm_disconnect_reg <= bus_req.wdata[7:0];
      if (wr_deb) debounce_reg <= {1'b0, bus_req.wdata[6:0]};
      if (wr_ptr) probe_pointer_reg <= {5'h00, bus_req.wdata[2:0]};
      if (wr_opt) hook_options_reg <= bus_req.wdata[7:0];
    end
  end

  // Indirect words; pair words take all 16 bits, hook limits 6 bits and coefficient 13
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hook_upper_reg <= `LPS_RST_WORD;
      hook_lower_reg <= `LPS_RST_WORD;
      hook_coeff_reg <= `LPS_RST_WORD;
      pair_limit_reg <= '0;
      pair_pole_reg <= '0;
    end else begin
      if (wr_upper) hook_upper_reg <= {10'h000, bus_req.wdata[5:0]};
      if (wr_lower) hook_lower_reg <= {10'h000, bus_req.wdata[5:0]};
      if (wr_coeff) hook_coeff_reg <= {3'h0, bus_req.wdata[12:0]};
      for (int p = 0; p < 3; p++) begin
        if (wr_limit[p]) pair_limit_reg[p] <= bus_req.wdata;
        if (wr_pole[p]) pair_pole_reg[p] <= bus_req.wdata;
      end
    end
  end

  // Probe readout: live, unfiltered power of the chosen transistor
  wire logic probe_valid = probe_pointer_reg[2:0] < 3'h6;
  wire logic [7:0] probe_value = probe_valid ?
      mon.power[probe_pointer_reg[2:0]] : 8'h00;

  // Read decode; unmapped addresses read zero
  logic [15:0] rdata_next;
  always_comb begin
    if (bus_req.addr == `LPS_OFS_EVENT_PENDING) rdata_next = {8'h00, event_pending_reg};
    else if (bus_req.addr == `LPS_OFS_EVENT_ENABLE) rdata_next = {8'h00, event_enable_reg};
    else if (bus_req.addr == `LPS_OFS_LINE_STATE) rdata_next = {13'h0000, line_state_select};
    else if (bus_req.addr == `LPS_OFS_ALARM_DISC) rdata_next = {8'h00, alarm_disconnect_reg};
    else if (bus_req.addr == `LPS_OFS_HOOK_STATUS) rdata_next = {15'h0000, closure_detected};
    else if (bus_req.addr == `LPS_OFS_HOOK_DEBOUNCE) rdata_next = {8'h00, debounce_reg};
    else if (bus_req.addr == `LPS_OFS_PROBE_POINTER) rdata_next = {8'h00, probe_pointer_reg};
    else if (bus_req.addr == `LPS_OFS_PROBE_READOUT) rdata_next = {8'h00, probe_value};
    else if (bus_req.addr == `LPS_OFS_LINE_TRIM) rdata_next = {8'h00, cal_active, 7'h00};
    else if (bus_req.addr == `LPS_OFS_HOOK_OPTIONS) rdata_next = {8'h00, hook_options_reg};
    else if (bus_req.addr == `LPS_OFS_HOOK_UPPER) rdata_next = hook_upper_reg;
    else if (bus_req.addr == `LPS_OFS_HOOK_LOWER) rdata_next = hook_lower_reg;
    else if (bus_req.addr == `LPS_OFS_HOOK_COEFF) rdata_next = hook_coeff_reg;
    else if (bus_req.addr == `LPS_OFS_PAIR_A_LIMIT) rdata_next = pair_limit_reg[0];
    else if (bus_req.addr == `LPS_OFS_PAIR_B_LIMIT) rdata_next = pair_limit_reg[1];
    else if (bus_req.addr == `LPS_OFS_PAIR_C_LIMIT) rdata_next = pair_limit_reg[2];
    else if (bus_req.addr == `LPS_OFS_PAIR_A_POLE) rdata_next = pair_pole_reg[0];
    else if (bus_req.addr == `LPS_OFS_PAIR_B_POLE) rdata_next = pair_pole_reg[1];
    else if (bus_req.addr == `LPS_OFS_PAIR_C_POLE) rdata_next = pair_pole_reg[2];
    else rdata_next = `LPS_RST_WORD;
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= `LPS_RST_WORD;
    end else begin
      bus_rdata <= bus_req.rd ? rdata_next : `LPS_RST_WORD;
    end
  end

endmodule : lps_supervisor
`default_nettype wire

// ==== core/lps_defs.svh ====
// Constants for the line power and hook supervisor: register offsets,
// field positions, reset values and timing figures.
// Assumes inclusion by bare name; the low-pass filter stage uses these numbers without including them.
`ifndef LPS_DEFS_SVH
`define LPS_DEFS_SVH

// Clock and rates
`define LPS_MCLK_HZ 10000000
`define LPS_SAMPLE_RATE_HZ 800
`define LPS_CAL_TIME_US 2000

// Direct register offsets
`define LPS_OFS_EVENT_PENDING 8'h13
`define LPS_OFS_EVENT_ENABLE 8'h16
`define LPS_OFS_LINE_STATE 8'h40
`define LPS_OFS_ALARM_DISC 8'h43
`define LPS_OFS_HOOK_STATUS 8'h44
`define LPS_OFS_HOOK_DEBOUNCE 8'h45
`define LPS_OFS_PROBE_POINTER 8'h4C
`define LPS_OFS_PROBE_READOUT 8'h4D
`define LPS_OFS_LINE_TRIM 8'h60
`define LPS_OFS_HOOK_OPTIONS 8'h6C

// Indirect register window
`define LPS_OFS_HOOK_UPPER 8'h9C
`define LPS_OFS_PAIR_A_LIMIT 8'hA0
`define LPS_OFS_PAIR_B_LIMIT 8'hA1
`define LPS_OFS_PAIR_C_LIMIT 8'hA2
`define LPS_OFS_HOOK_COEFF 8'hA3
`define LPS_OFS_PAIR_A_POLE 8'hA5
`define LPS_OFS_PAIR_B_POLE 8'hA6
`define LPS_OFS_PAIR_C_POLE 8'hA7
`define LPS_OFS_HOOK_LOWER 8'hAB

// Field positions
`define LPS_BIT_CLOSURE_PEND 1
`define LPS_BIT_ALARM_LSB 2
`define LPS_BIT_AUTO_DISC 0
`define LPS_BIT_TRIM_START 7
`define LPS_BIT_HYST_ON 0
`define LPS_BIT_BY_VOLTAGE 2

// Reset values
`define LPS_LINE_OPEN 3'h0
`define LPS_RST_BYTE 8'h00
`define LPS_RST_WORD 16'h0000

// Filter and scale figures
`define LPS_COEF_SHIFT 15
`define LPS_PAIR_AC_SHIFT 7
`define LPS_PAIR_B_SHIFT 4
`define LPS_LOOP_SHIFT 10

// Silicon revision C feature strap
`define LPS_REV_C_FEATURES 1'b1

`endif

// ==== core/lps_pkg.sv ====
// Types shared by the line power and hook supervisor files.
// Assumes nothing beyond a SystemVerilog compiler.
package lps_pkg;

  // One register port request, all on mclk
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } lps_bus_req_type;

  // Monitor converter readings, produced on mclk
  typedef struct packed {
    logic [5:0][7:0] power;
    logic [6:0] loop_current_sample;
    logic [6:0] loop_voltage_sample;
    logic [2:0] line_state_shadow;
  } lps_monitor_type;

  // Calibration sequencer, Gray coded along idle, run, done
  typedef enum logic [1:0] {
    LPS_CAL_IDLE = 2'b00,
    LPS_CAL_RUN = 2'b01,
    LPS_CAL_DONE = 2'b11
  } lps_cal_state_type;

endpackage : lps_pkg

// ==== core/lps_lowpass.sv ====
// First order low-pass filter stage with a programmable coefficient.
// Assumes an active-low reset with asynchronous assert and synchronous release, and a one-cycle sample enable.
`timescale 1ns/10ps
`default_nettype none
module lps_lowpass (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sample in
  input wire logic sample_en,
  input wire logic [15:0] sample_in,
  input wire logic [15:0] coeff,
  // Filtered value
  output var logic [15:0] filt_out
);

  // Difference between new sample and state, signed
  wire logic signed [16:0] diff;
  // Scaled step; coefficient full scale is one shift unit
  wire logic signed [33:0] prod;
  wire logic signed [16:0] step;
  wire logic signed [17:0] sum;

  assign diff = $signed({1'b0, sample_in}) - $signed({1'b0, filt_out});
  assign prod = diff * $signed({1'b0, coeff});
  // Step stays within the difference only for coeff up to 16'h8000; larger values can overflow 16 bits
  assign step = prod[`LPS_COEF_SHIFT+16:`LPS_COEF_SHIFT];
  assign sum = $signed({2'b00, filt_out}) + 18'(step);

  // State only moves on a sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_out <= `LPS_RST_WORD;
    end else if (sample_en) begin
      filt_out <= sum[15:0];
    end
  end

endmodule : lps_lowpass
`default_nettype wire

// ==== tb/lps_supervisor_props.sv ====
// Port checker for the line power and hook supervisor.
// Assumes it is bound to lps_supervisor and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "lps_defs.svh"
module lps_supervisor_props
  import lps_pkg::*;
#(
  parameter int SAMPLE_DIV = 8,
  parameter int CAL_CYCLES = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire lps_bus_req_type bus_req,
  input wire logic [15:0] bus_rdata,
  // Monitor readings and outputs
  input wire lps_monitor_type mon,
  input wire logic [2:0] line_state_select,
  input wire logic cal_active,
  input wire logic irq_request,
  input wire logic closure_detected
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // Length of the current calibration run, in cycles
  logic [15:0] cal_cnt_reg;
  logic [15:0] cal_cnt_next;
  assign cal_cnt_next = cal_active ? cal_cnt_reg + 16'h0001 : 16'h0000;
  // Counter cleared with the design so a mid-run reset restarts it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cal_cnt_reg <= 16'h0000;
    end else begin
      cal_cnt_reg <= cal_cnt_next;
    end
  end

  // Write to the line state register
  wire logic wr_line = bus_req.wr && (bus_req.addr == `LPS_OFS_LINE_STATE);
  // Accepted start: idle for two cycles, so the done step is not hit
  sequence cal_start_s;
    bus_req.wr && (bus_req.addr == `LPS_OFS_LINE_TRIM) && bus_req.wdata[7]
      && !cal_active && !$past(cal_active);
  endsequence

  rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  status_read_a: assert property (bus_req.rd && bus_req.addr == `LPS_OFS_HOOK_STATUS
    |=> bus_rdata[15:1] == 15'h0000
    && (bus_rdata[0] == closure_detected || bus_rdata[0] == $past(closure_detected)))
    else $error("status read does not match closure flag");
  cal_start_a: assert property (cal_start_s |=> cal_active)
    else $error("calibration did not start");
  // Sequencer holds the run flag for exactly CAL_CYCLES clocks
  cal_length_a: assert property ($fell(cal_active) |-> cal_cnt_reg == 16'(CAL_CYCLES))
    else $error("calibration length wrong");
  cal_bound_a: assert property (cal_cnt_reg <= 16'(CAL_CYCLES))
    else $error("calibration overran");
  open_reset_a: assert property ($rose(rstn) |-> (line_state_select == 3'h0)[*3])
    else $error("line not open after reset");
  line_write_a: assert property (wr_line
    |=> line_state_select == $past(bus_req.wdata[2:0]) || line_state_select == 3'h0)
    else $error("line state write lost");
  line_hold_a: assert property (!wr_line
    |=> $stable(line_state_select) || line_state_select == 3'h0)
    else $error("line state changed without cause");
  irq_clear_a: assert property ($fell(irq_request) |-> $past(bus_req.wr, 2)
    && ($past(bus_req.addr, 2) == `LPS_OFS_EVENT_PENDING
    || $past(bus_req.addr, 2) == `LPS_OFS_EVENT_ENABLE))
    else $error("interrupt dropped without a write");
  closure_gate_a: assert property ($changed(closure_detected)
    |-> $past(mon.line_state_shadow) inside {3'h1, 3'h2, 3'h5, 3'h6})
    else $error("closure changed outside on-hook states");
endmodule : lps_supervisor_props

bind lps_supervisor lps_supervisor_props #(.SAMPLE_DIV(SAMPLE_DIV), .CAL_CYCLES(CAL_CYCLES))
  u_props (.mclk(mclk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata), .mon(mon),
  .line_state_select(line_state_select), .cal_active(cal_active),
  .irq_request(irq_request), .closure_detected(closure_detected));
`default_nettype wire

// ==== tb/lps_supervisor_tb.sv ====
// Self-checking bench for the line power and hook supervisor.
// Assumes the bench drives the register port and monitor readings itself.
`timescale 1ns/10ps
`default_nettype none
`include "lps_defs.svh"
module lps_supervisor_tb;
  import lps_pkg::*;
  localparam int SDIV = 8; // Short sample tick
  localparam int CALC = 10; // Short calibration
  logic mclk;
  logic rstn;
  lps_bus_req_type bus_req;
  logic [15:0] bus_rdata;
  lps_monitor_type mon;
  logic [2:0] line_state_select;
  logic cal_active;
  logic irq_request;
  logic closure_detected;
  int fail_count;
  int compares;
  logic [7:0] rst_list [7] = '{8'h13, 8'h16, 8'h43, 8'h44, 8'h4C, 8'h6C, 8'h05};

  lps_supervisor #(.SAMPLE_DIV(SDIV), .CAL_CYCLES(CALC)) DUT (
    .mclk(mclk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata), .mon(mon),
    .line_state_select(line_state_select), .cal_active(cal_active),
    .irq_request(irq_request), .closure_detected(closure_detected));

  // 100 ns clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Count and report one comparison
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Counts, verdict, end of run
  task final_report;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // One-cycle write strobe
  task reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) bus_req <= '0;
  endtask : reg_wr

  // Read; data stands only in the cycle after the strobe
  task reg_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge mclk) bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge mclk) bus_req <= '0;
    #1 chk(bus_rdata & m, e);
  endtask : reg_chk

  task ticks(input int n);
    repeat (n * SDIV) @(posedge mclk);
  endtask : ticks

  // Bounded wait for closure (sel 0) or calibration flag (sel 1)
  task wait_lvl(input int sel, input logic v);
    int i;
    for (i = 0; i < 400 && (sel ? cal_active : closure_detected) !== v; i++) @(posedge mclk);
    if ((sel ? cal_active : closure_detected) !== v) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, !v, v);
      final_report();
    end
  endtask : wait_lvl

  initial begin
    rstn = 1'b0;
    bus_req = '0;
    mon = '0;
    fail_count = 0;
    compares = 0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    // Reset values, one unmapped address last
    chk({13'h0000, line_state_select}, 16'h0000);
    foreach (rst_list[k]) reg_chk(rst_list[k], 16'hFFFF, 16'h0000);
    $display("reset test done");
    // Field widths; reserved bits read zero
    reg_wr(`LPS_OFS_HOOK_DEBOUNCE, 16'hFFFF);
    reg_chk(`LPS_OFS_HOOK_DEBOUNCE, 16'hFFFF, 16'h007F);
    reg_wr(`LPS_OFS_HOOK_OPTIONS, 16'hFFFF);
    // Option register keeps all eight written bits
    reg_chk(`LPS_OFS_HOOK_OPTIONS, 16'hFFFF, 16'h00FF);
    reg_wr(`LPS_OFS_HOOK_OPTIONS, 16'h0000);
    $display("register test done");
    // Probe every pointer value, two unused
    @(posedge mclk) mon.power <= 48'h6655_4433_2211;
    for (int k = 0; k < 8; k++) begin
      reg_wr(`LPS_OFS_PROBE_POINTER, 16'(k));
      reg_chk(`LPS_OFS_PROBE_READOUT, 16'hFFFF, (k < 6) ? 16'(17 * (k + 1)) : 16'h0000);
    end
    $display("probe test done");
    // Overload on pair A with auto-disconnect
    reg_wr(`LPS_OFS_ALARM_DISC, 16'h0001);
    reg_wr(`LPS_OFS_LINE_STATE, 16'h0001);
    // Step off the edge that launches the new line state
    #1 chk({13'h0000, line_state_select}, 16'h0001);
    reg_wr(`LPS_OFS_PAIR_A_POLE, 16'h8000);
    reg_wr(`LPS_OFS_EVENT_ENABLE, 16'h0004);
    ticks(3);
    reg_chk(`LPS_OFS_EVENT_PENDING, 16'h0004, 16'h0004);
    chk({15'h0000, irq_request}, 16'h0001);
    chk({13'h0000, line_state_select}, 16'h0000);
    reg_wr(`LPS_OFS_EVENT_ENABLE, 16'h0000);
    repeat (3) @(posedge mclk);
    #1 chk({15'h0000, irq_request}, 16'h0000);
    reg_chk(`LPS_OFS_EVENT_PENDING, 16'h0004, 16'h0004);
    reg_wr(`LPS_OFS_PAIR_A_LIMIT, 16'hFFFF);
    ticks(2);
    reg_wr(`LPS_OFS_EVENT_PENDING, 16'h00FC);
    reg_chk(`LPS_OFS_EVENT_PENDING, 16'hFFFF, 16'h0000);
    // Pair B: own limit and smaller scale, equal is no overload
    @(posedge mclk) mon.power <= 48'h0000_0011_0000;
    reg_wr(`LPS_OFS_PAIR_B_POLE, 16'h8000);
    reg_wr(`LPS_OFS_PAIR_B_LIMIT, 16'h0110);
    ticks(3);
    reg_chk(`LPS_OFS_EVENT_PENDING, 16'h0030, 16'h0000);
    reg_wr(`LPS_OFS_PAIR_B_LIMIT, 16'h010F);
    ticks(3);
    reg_chk(`LPS_OFS_EVENT_PENDING, 16'h0030, 16'h0010);
    $display("power alarm test done");
    // Loop closure: ignored while open, then debounced
    reg_wr(`LPS_OFS_PAIR_B_LIMIT, 16'hFFFF);
    reg_wr(`LPS_OFS_HOOK_COEFF, 16'h1FFF);
    reg_wr(`LPS_OFS_HOOK_UPPER, 16'h000A);
    reg_wr(`LPS_OFS_HOOK_DEBOUNCE, 16'h0002);
    reg_wr(`LPS_OFS_EVENT_ENABLE, 16'h0002);
    reg_wr(`LPS_OFS_EVENT_PENDING, 16'h00FC);
    @(posedge mclk) mon.loop_current_sample <= 7'h14;
    ticks(10);
    #1 chk({15'h0000, closure_detected}, 16'h0000);
    @(posedge mclk) mon.line_state_shadow <= 3'h1;
    ticks(3);
    #1 chk({15'h0000, closure_detected}, 16'h0000);
    wait_lvl(0, 1'b1);
    reg_chk(`LPS_OFS_HOOK_STATUS, 16'hFFFF, 16'h0001);
    reg_chk(`LPS_OFS_EVENT_PENDING, 16'h0002, 16'h0002);
    chk({15'h0000, irq_request}, 16'h0001);
    // Hysteresis holds between the bounds
    reg_wr(`LPS_OFS_HOOK_OPTIONS, 16'h0001);
    reg_wr(`LPS_OFS_HOOK_LOWER, 16'h0004);
    @(posedge mclk) mon.loop_current_sample <= 7'h08;
    ticks(20);
    #1 chk({15'h0000, closure_detected}, 16'h0001);
    @(posedge mclk) mon.loop_current_sample <= 7'h00;
    wait_lvl(0, 1'b0);
    // Voltage mode: low voltage means closure
    // Voltage first, so the filter never sees a zero voltage sample
    @(posedge mclk) mon.loop_voltage_sample <= 7'h1E;
    reg_wr(`LPS_OFS_HOOK_OPTIONS, 16'h0004);
    ticks(10);
    #1 chk({15'h0000, closure_detected}, 16'h0000);
    @(posedge mclk) mon.loop_voltage_sample <= 7'h02;
    wait_lvl(0, 1'b1);
    // Voltage hysteresis: hold between bounds, release above upper
    reg_wr(`LPS_OFS_HOOK_OPTIONS, 16'h0005);
    @(posedge mclk) mon.loop_voltage_sample <= 7'h08;
    ticks(20);
    #1 chk({15'h0000, closure_detected}, 16'h0001);
    @(posedge mclk) mon.loop_voltage_sample <= 7'h1E;
    wait_lvl(0, 1'b0);
    $display("closure test done");
    // Calibration start bit clears itself
    // One run, line held in an on-hook state
    reg_wr(`LPS_OFS_LINE_TRIM, 16'h0080);
    reg_chk(`LPS_OFS_LINE_TRIM, 16'h0080, 16'h0080);
    wait_lvl(1, 1'b0);
    reg_chk(`LPS_OFS_LINE_TRIM, 16'h0080, 16'h0000);
    $display("calibration test done");
    final_report();
  end
endmodule : lps_supervisor_tb
`default_nettype wire
